// ---- verilog/smbus_slave_pkg.sv ----
// Shared constants and carrier types for the serial register access slave.
// Assumes a 200 MHz core clock and a slow two-wire link sampled by it.
package smbus_slave_pkg;

  // ----------------------------------------------------------------
  // Addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] FIXED_ADDR      = 7'h2E;
  localparam logic [6:0] STRAP_ADDR_LOW  = 7'h2C;
  localparam logic [6:0] STRAP_ADDR_HIGH = 7'h2D;
  localparam logic [6:0] ALERT_REPLY_ADDR = 7'h0C;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 200;
  localparam int BUS_TIMEOUT_MS   = 35;
  localparam int BUS_TIMEOUT_CYC  = BUS_TIMEOUT_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         TIMEOUT_DIS_BIT = 6;
  localparam logic [7:0] POINTER_RESET   = 8'h00;
  localparam logic [3:0] BIT_COUNT_ACK   = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WACK  = 3'b011,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b110,
    ST_RACK  = 3'b111
  } link_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } line_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

endpackage

// ---- verilog/line_sync.sv ----
// Two flip-flop synchroniser for the serial clock and data pins.
// Assumes pins are asynchronous to clock_i.
`timescale 1ns/1ps
module line_sync (
  input  wire logic                  clock_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  enable_i,
  input  wire smbus_slave_pkg::line_t pins_i,
  output      smbus_slave_pkg::line_t line_o
);
  import smbus_slave_pkg::*;

  typedef struct packed {
    line_t meta;
    line_t sync;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (enable_i) begin
      state_nxt.meta = pins_i;
      state_nxt.sync = state_r.meta;
    end
  end

  // Idle bus level is high on both wires
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= '1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign line_o = state_r.sync;
endmodule

// ---- verilog/bus_timeout.sv ----
// Counter that flags a lock-up when the link shows no activity.
// Assumes activity_i pulses on every sampled edge of either wire.
`timescale 1ns/1ps
module bus_timeout #(
  parameter int LIMIT = smbus_slave_pkg::BUS_TIMEOUT_CYC
) (
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  input  wire logic enable_i,
  input  wire logic busy_i,
  input  wire logic activity_i,
  input  wire logic disable_i,
  output      logic expired_o
);
  import smbus_slave_pkg::*;

  initial begin
    if (LIMIT < 2) $error("bus_timeout: LIMIT too small");
  end

  typedef struct packed {
    logic [31:0] count;
    logic        expired;
  } timeout_state_t;

  timeout_state_t state_r;
  timeout_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (enable_i) begin
      state_nxt.expired = 1'b0;
      if (!busy_i || activity_i || disable_i) begin
        state_nxt.count = '0;
      end else if (state_r.count == 32'(LIMIT - 1)) begin
        state_nxt.count   = '0;
        state_nxt.expired = 1'b1;
      end else begin
        state_nxt.count = state_r.count + 32'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign expired_o = state_r.expired;
endmodule

// ---- verilog/smbus_slave_register_access.sv ----
// Two-wire slave giving a host access to 8-bit internal registers.
// Assumes register storage lives outside and answers read_data_i combinationally
// for the address on pointer_o; link pins arrive asynchronously.
//
// Overview of operation
// RULE1 - Address enable strap high at power-up selects fixed address 0101110.
// RULE2 - Strap low selects 0101100 or 0101101 from the select strap.
// RULE3 - Strap address sampled at power-up, locked on first match, later changes ignored.
// RULE4 - Start is SDA falling with SCL high; eight bits shift in, MSB first.
// RULE5 - Matching address gets acknowledge on ninth clock; otherwise idle until start.
// RULE6 - Direction bit zero means master write, one means master read.
// RULE7 - Each byte is eight data clocks plus one acknowledge clock.
// RULE8 - SDA rising with SCL high is a stop ending the transfer.
// RULE9 - Master ends a read with not-acknowledge then a stop.
// RULE10 - Direction holds for whole transfer; change needs a new start.
// RULE11 - Writes carry one or two bytes; reads return one byte.
// RULE12 - First write byte loads the address pointer only.
// RULE13 - Second write byte is stored to the register the pointer selects.
// RULE14 - Reads return the selected register without rewriting the pointer.
// RULE15 - Repeated start acts as a fresh start and keeps the pointer.
// RULE16 - Send byte, receive byte and read byte forms are all served.
// RULE17 - Optional open-drain alert output pulled low on out-of-limit events.
// RULE18 - Unless timeout disable bit is set, release bus after 35 ms idle.
// RULE19 - With alert low, answer alert reply address read with own address.
// RULE20 - Pointer keeps its value until another write overwrites it.
`timescale 1ns/1ps
module smbus_slave_register_access
  import smbus_slave_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYC
) (
  input  wire logic                       clock_i,
  input  wire logic                       reset_n_i,
  input  wire logic                       enable_i,
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  output      logic                       sda_o,
  output      logic                       sda_oe_o,
  input  wire logic                       strap_address_enable_i,
  input  wire logic                       strap_select_i,
  input  wire logic                       alert_pin_enable_i,
  input  wire logic                       alert_event_i,
  input  wire logic [7:0]                 config_i,
  input  wire logic [7:0]                 read_data_i,
  output      logic [7:0]                 pointer_o,
  output      smbus_slave_pkg::reg_write_t write_o,
  output      logic                       alert_o,
  output      logic                       alert_oe_o
);
  import smbus_slave_pkg::*;

  initial begin
    if (TIMEOUT_CYCLES < 2) $error("TIMEOUT_CYCLES too small");
  end

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe_r;
  logic       rst_n;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_pipe_r <= 2'b00;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_r[1];

  line_t line;
  line_t strap_line;

  line_sync u_link_sync (
    .clock_i   (clock_i),
    .reset_n_i (rst_n),
    .enable_i  (enable_i),
    .pins_i    ({scl_i, sda_i}),
    .line_o    (line)
  );

  // Straps reuse the same two-stage sampling; scl field carries enable strap
  line_sync u_strap_sync (
    .clock_i   (clock_i),
    .reset_n_i (rst_n),
    .enable_i  (enable_i),
    .pins_i    ({strap_address_enable_i, strap_select_i}),
    .line_o    (strap_line)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    link_state_t st;
    line_t       prev;
    logic [7:0]  shift;
    logic [3:0]  bits;
    logic        read_dir;
    logic        alert_reply;
    logic        got_pointer;
    logic        ack_drive;
    logic        sda_drive;
    logic [7:0]  pointer;
    reg_write_t  wr;
    logic [2:0]  strap_wait;
    logic        strap_taken;
    logic        locked;
    logic [6:0]  own_addr;
    logic        alert_n;
    logic        alert_oe;
  } core_state_t;

  core_state_t s_r;
  core_state_t s_nxt;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic activity;
  logic expired;

  assign scl_rise   = line.scl & ~s_r.prev.scl;
  assign scl_fall   = ~line.scl & s_r.prev.scl;
  assign start_seen = line.scl & s_r.prev.scl & s_r.prev.sda & ~line.sda;  // RULE4
  assign stop_seen  = line.scl & s_r.prev.scl & ~s_r.prev.sda & line.sda;  // RULE8
  assign activity   = (line.scl ^ s_r.prev.scl) | (line.sda ^ s_r.prev.sda);

  bus_timeout #(
    .LIMIT (TIMEOUT_CYCLES)
  ) u_timeout (
    .clock_i    (clock_i),
    .reset_n_i  (rst_n),
    .enable_i   (enable_i),
    .busy_i     (s_r.st != ST_IDLE),
    .activity_i (activity),
    .disable_i  (config_i[TIMEOUT_DIS_BIT]),  // RULE18
    .expired_o  (expired)
  );

  // Address select decode, used for strap capture only; matching compares against own_addr
  function automatic logic [6:0] strap_address(input logic en, input logic sel);
    if (en) begin
      return FIXED_ADDR;  // RULE1
    end
    return sel ? STRAP_ADDR_HIGH : STRAP_ADDR_LOW;  // RULE2
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [7:0] addr_byte;

  always_comb begin
    s_nxt     = s_r;
    addr_byte = {s_r.shift[6:0], line.sda};
    if (enable_i) begin
      s_nxt.prev     = line;
      s_nxt.wr.valid = 1'b0;

      // Strap captured a few cycles after release, once synchronisers fill
      if (!s_r.strap_taken) begin
        if (s_r.strap_wait == 3'h7) begin
          s_nxt.strap_taken = 1'b1;
          s_nxt.own_addr    = strap_address(strap_line.scl, strap_line.sda);  // RULE3
        end else begin
          s_nxt.strap_wait = s_r.strap_wait + 3'h1;
        end
      end

      // Alert pin: open drain, enable high while pulling low
      s_nxt.alert_n   = ~(alert_pin_enable_i & alert_event_i);  // RULE17
      s_nxt.alert_oe  = alert_pin_enable_i & alert_event_i;  // RULE17

      if (scl_fall) begin
        s_nxt.sda_drive = 1'b0;
      end

      if (start_seen) begin
        s_nxt.st        = ST_ADDR;  // RULE15
        s_nxt.bits      = '0;
        s_nxt.sda_drive = 1'b0;
        s_nxt.got_pointer = 1'b0;
      end else if (stop_seen || expired) begin
        s_nxt.st        = ST_IDLE;  // RULE8 RULE18
        s_nxt.sda_drive = 1'b0;
      end else begin
        unique case (s_r.st)
          ST_IDLE: begin
          end
          ST_ADDR: begin
            if (scl_rise) begin
              s_nxt.shift = addr_byte;  // RULE4
              s_nxt.bits  = s_r.bits + 4'h1;
              // Lock happens on the rise opening the eighth clock
              if (s_r.bits == 4'h7 && !s_r.locked &&
                  s_r.shift[6:0] == s_r.own_addr) begin
                s_nxt.locked = 1'b1;  // RULE3
              end
              if (s_r.bits == 4'h7) begin
                s_nxt.bits        = '0;
                s_nxt.read_dir    = line.sda;  // RULE6 RULE10
                s_nxt.alert_reply = s_r.shift[6:0] == ALERT_REPLY_ADDR &&
                                    s_r.alert_oe && line.sda;  // RULE19
                if (s_r.shift[6:0] == s_r.own_addr || (s_r.shift[6:0] == ALERT_REPLY_ADDR &&
                    s_r.alert_oe && line.sda)) begin
                  s_nxt.st        = ST_WACK;
                  s_nxt.ack_drive = 1'b1;  // RULE5
                end else begin
                  s_nxt.st = ST_IDLE;  // RULE5
                end
              end
            end
          end
          ST_WACK: begin
            // Acknowledge driven during the low phase before the ninth rise
            if (scl_fall && s_r.ack_drive) begin
              s_nxt.sda_drive = 1'b1;  // RULE5 RULE7
              s_nxt.ack_drive = 1'b0;
            end else if (scl_fall && !s_r.ack_drive) begin
              if (s_r.read_dir) begin
                s_nxt.st    = ST_RDATA;  // RULE14 RULE16
                s_nxt.shift = s_r.alert_reply ? {s_r.own_addr, 1'b1} : read_data_i;  // RULE19
                s_nxt.sda_drive = s_r.alert_reply ? ~s_r.own_addr[6] : ~read_data_i[7];
                s_nxt.bits  = '0;
              end else begin
                s_nxt.st   = ST_WDATA;
                s_nxt.bits = '0;
              end
            end
          end
          ST_WDATA: begin
            if (scl_rise) begin
              s_nxt.shift = {s_r.shift[6:0], line.sda};
              s_nxt.bits  = s_r.bits + 4'h1;
              if (s_r.bits == 4'h7) begin
                s_nxt.bits = '0;
                if (!s_r.got_pointer) begin
                  s_nxt.pointer     = {s_r.shift[6:0], line.sda};  // RULE12 RULE20
                  s_nxt.got_pointer = 1'b1;
                  s_nxt.st          = ST_WACK;
                  s_nxt.ack_drive   = 1'b1;
                end else begin
                  s_nxt.wr.valid = 1'b1;  // RULE13
                  s_nxt.wr.addr  = s_r.pointer;
                  s_nxt.wr.data  = {s_r.shift[6:0], line.sda};
                  // Extra bytes rewrite the same register; pointer never steps
                  s_nxt.st        = ST_WACK;  // RULE11
                  s_nxt.ack_drive = 1'b1;
                  s_nxt.got_pointer = 1'b1;
                end
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (s_r.bits == 4'h7) begin
                s_nxt.st        = ST_RACK;
                s_nxt.sda_drive = 1'b0;
              end else begin
                s_nxt.bits      = s_r.bits + 4'h1;
                s_nxt.shift     = {s_r.shift[6:0], 1'b0};
                s_nxt.sda_drive = ~s_r.shift[6];
              end
            end
          end
          ST_RACK: begin
            // One byte per read: return to idle on the acknowledge clock rise, whatever the master drives
            if (scl_rise) begin
              s_nxt.st = ST_IDLE;  // RULE9 RULE11
            end
          end
          default: begin
            s_nxt.st = ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s_r          <= '0;
      s_r.prev     <= '1;
      s_r.st       <= ST_IDLE;
      s_r.pointer  <= POINTER_RESET;
      s_r.own_addr <= FIXED_ADDR;
      s_r.alert_n  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sda_o      = 1'b0;
  assign sda_oe_o   = s_r.sda_drive;
  assign pointer_o  = s_r.pointer;
  assign write_o    = s_r.wr;
  assign alert_o    = s_r.alert_n;
  assign alert_oe_o = s_r.alert_oe;
endmodule

// ---- dv/smbus_slave_register_access_assertions.sv ----
// Port-level checks for the two-wire register access slave.
// Assumes binding onto the top module; link pins are slow against clock_i.
`timescale 1ns/1ps
module smbus_slave_register_access_assertions
  import smbus_slave_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYC
) (
  input wire logic                        clock_i,
  input wire logic                        reset_n_i,
  input wire logic                        enable_i,
  input wire logic                        scl_i,
  input wire logic                        sda_i,
  input wire logic                        sda_o,
  input wire logic                        sda_oe_o,
  input wire logic                        strap_address_enable_i,
  input wire logic                        strap_select_i,
  input wire logic                        alert_pin_enable_i,
  input wire logic                        alert_event_i,
  input wire logic [7:0]                  config_i,
  input wire logic [7:0]                  read_data_i,
  input wire logic [7:0]                  pointer_o,
  input wire smbus_slave_pkg::reg_write_t write_o,
  input wire logic                        alert_o,
  input wire logic                        alert_oe_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  a_sda_low_only: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data pin moved while link clock high");
  a_reset_quiet: assert property (disable iff (1'b0)
    !reset_n_i |-> !sda_oe_o && !write_o.valid && pointer_o == POINTER_RESET)
    else $error("outputs active during reset");
  a_write_pulse: assert property (write_o.valid |=> !write_o.valid)
    else $error("write strobe longer than one cycle");
  a_write_at_ptr: assert property (write_o.valid |-> write_o.addr == pointer_o)
    else $error("write not aimed at pointer");
  a_write_acked: assert property (write_o.valid |-> ##[0:15] sda_oe_o)
    else $error("data byte not acknowledged");
  a_ptr_then_ack: assert property ($changed(pointer_o) |-> ##[0:15] sda_oe_o)
    else $error("pointer load without acknowledge");
  a_alert_level: assert property (alert_oe_o |-> !alert_o)
    else $error("alert driven but not low");
  a_alert_follows: assert property ((alert_pin_enable_i && alert_event_i) [*8]
    |-> alert_oe_o)
    else $error("alert not asserted on event");
  a_alert_off: assert property (!alert_pin_enable_i [*8] |-> !alert_oe_o)
    else $error("alert driven while pin disabled");
  a_freeze_hold: assert property (!enable_i ##1 !enable_i
    |-> $stable(pointer_o) && $stable(sda_oe_o))
    else $error("state moved while disabled");
endmodule

bind smbus_slave_register_access smbus_slave_register_access_assertions #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) u_chk (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .enable_i(enable_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .strap_address_enable_i(strap_address_enable_i), .strap_select_i(strap_select_i),
  .alert_pin_enable_i(alert_pin_enable_i), .alert_event_i(alert_event_i),
  .config_i(config_i), .read_data_i(read_data_i), .pointer_o(pointer_o),
  .write_o(write_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o)
);

// ---- dv/smbus_host_model.sv ----
// Bus master model driving the link clock and pulling the data line low.
// Assumes a pulled-up data wire resolved by the bench; clock idles high.
`timescale 1ns/1ps
module smbus_host_model (
  input  wire logic sda_i,
  output      logic scl_o,
  output      logic sda_low_o
);
  // ----------------------------------------------------------------
  // Link timing, 64 ns clock period
  // ----------------------------------------------------------------
  localparam time Q = 16;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic bit_out(input logic b);
    sda_low_o = !b;
    #Q scl_o = 1'b1;
    #(2*Q) scl_o = 1'b0;
    #Q;
  endtask
  task automatic bit_in(output logic b);
    sda_low_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q b = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask
  // Also serves as repeated start from a low clock
  task automatic start();
    sda_low_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b1;
    #Q scl_o = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b0;
    #(2*Q);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = !a;
  endtask
  task automatic rbyte(output logic [7:0] d, input logic nack);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(nack);
  endtask
endmodule

// ---- dv/smbus_slave_register_access_bench.sv ----
// Self-checking bench for the two-wire register access slave.
// Assumes the host model on the link and a register file echoing pointer ^ 5A.
`timescale 1ns/1ps
module smbus_slave_register_access_bench;
  import smbus_slave_pkg::*;
  logic       clock_i = 1'b0, reset_n = 1'b1, en = 1'b1, sae = 1'b1, ssel = 1'b0;
  logic       ape = 1'b0, aev = 1'b0, sda_o, sda_oe, alert, alert_oe, scl, m_low, ack;
  logic [7:0] cfg = 8'h00, ptr, rdata, b;
  reg_write_t wr, wr_last;
  int         n_fail = 0, n_tests = 0, n_wr = 0, n0;
  wire        sda_line = !(m_low || (sda_oe && !sda_o));

  always #2.5 clock_i = ~clock_i;
  assign rdata = ptr ^ 8'h5A;
  always @(posedge clock_i) if (wr.valid === 1'b1) begin
    n_wr++;
    wr_last = wr;
  end

  smbus_slave_register_access #(.TIMEOUT_CYCLES(200)) u_dut (
    .clock_i(clock_i), .reset_n_i(reset_n), .enable_i(en), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .strap_address_enable_i(sae), .strap_select_i(ssel),
    .alert_pin_enable_i(ape), .alert_event_i(aev), .config_i(cfg), .read_data_i(rdata),
    .pointer_o(ptr), .write_o(wr), .alert_o(alert), .alert_oe_o(alert_oe));
  smbus_host_model u_host (.sda_i(sda_line), .scl_o(scl), .sda_low_o(m_low));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string m);
    chk8({7'h00, got}, {7'h00, exp}, m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic do_reset(input logic a, input logic s);
    cyc(1);
    reset_n = 1'b0;
    sae = a;
    ssel = s;
    cyc(6);
    reset_n = 1'b1;
    cyc(25);
    chk8(ptr, POINTER_RESET, "pointer reset");
  endtask
  task automatic probe(input logic [6:0] a, input logic exp);
    u_host.start();
    u_host.wbyte({a, 1'b0}, ack);
    u_host.stop();
    chk1(ack, exp, "address ack");
  endtask
  task automatic rd(input logic [6:0] a, input logic rs, output logic [7:0] d);
    if (rs) u_host.start();
    u_host.wbyte({a, 1'b1}, ack);
    chk1(ack, 1'b1, "read ack");
    u_host.rbyte(d, 1'b1);
    u_host.stop();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_write();
    n0 = n_wr;
    u_host.start();
    u_host.wbyte({FIXED_ADDR, 1'b0}, ack);
    chk1(ack, 1'b1, "fixed address");
    u_host.wbyte(8'h40, ack);
    chk8(ptr, 8'h40, "pointer load");
    u_host.wbyte(8'hA5, ack);
    chk1(ack, 1'b1, "data ack");
    u_host.stop();
    chk8(8'(n_wr - n0), 8'h01, "write count");
    chk8(wr_last.addr, 8'h40, "write addr");
    chk8(wr_last.data, 8'hA5, "write data");
  endtask
  task automatic t_send_recv(input logic rs);
    n0 = n_wr;
    u_host.start();
    u_host.wbyte({FIXED_ADDR, 1'b0}, ack);
    u_host.wbyte(8'h23 ^ {7'h00, rs}, ack);
    if (!rs) u_host.stop();
    chk8(8'(n_wr - n0), 8'h00, "send byte wrote");
    rd(FIXED_ADDR, 1'b1, b);
    chk8(b, 8'h23 ^ {7'h00, rs} ^ 8'h5A, "read data");
    chk8(ptr, 8'h23 ^ {7'h00, rs}, "pointer kept");
  endtask
  task automatic t_miss();
    u_host.start();
    u_host.wbyte({7'h2F, 1'b0}, ack);
    chk1(ack, 1'b0, "foreign address");
    u_host.wbyte(8'h11, ack);
    u_host.stop();
    chk1(ack, 1'b0, "idle after miss");
    chk8(ptr, 8'h22, "pointer untouched");
  endtask
  task automatic t_strap();
    do_reset(1'b0, 1'b1);
    probe(STRAP_ADDR_HIGH, 1'b1);
    probe(FIXED_ADDR, 1'b0);
    ssel = 1'b0;
    probe(STRAP_ADDR_HIGH, 1'b1);
    probe(STRAP_ADDR_LOW, 1'b0);
    do_reset(1'b0, 1'b0);
    probe(STRAP_ADDR_LOW, 1'b1);
    do_reset(1'b1, 1'b1);
    probe(FIXED_ADDR, 1'b1);
  endtask
  // Host stalls with clock low while the slave holds its acknowledge
  task automatic t_timeout();
    for (int c = 0; c < 2; c++) begin
      cfg = (c == 1) ? 8'h40 : 8'h00;
      u_host.start();
      for (int i = 7; i >= 0; i--) u_host.bit_out(i == 0 ? 1'b0 : FIXED_ADDR[i - 1]);
      cyc(10);
      chk1(sda_oe, 1'b1, "ack driven");
      cyc(250);
      chk1(sda_oe, c == 1, "bus release");
      u_host.bit_in(ack);
      u_host.stop();
    end
    cfg = 8'h00;
  endtask
  task automatic t_alert();
    ape = 1'b1;
    aev = 1'b1;
    cyc(10);
    chk1(alert_oe, 1'b1, "alert driven");
    chk1(alert, 1'b0, "alert low");
    rd(ALERT_REPLY_ADDR, 1'b1, b);
    chk8(b, {FIXED_ADDR, 1'b1}, "alert reply");
    aev = 1'b0;
    ape = 1'b0;
    cyc(10);
    chk1(alert_oe, 1'b0, "alert released");
  endtask
  // Link traffic while frozen must leave no trace
  task automatic t_freeze();
    cyc(1);
    en = 1'b0;
    u_host.start();
    u_host.wbyte({FIXED_ADDR, 1'b0}, ack);
    chk1(ack, 1'b0, "ack while frozen");
    u_host.wbyte(8'h77, ack);
    u_host.stop();
    cyc(1);
    en = 1'b1;
    cyc(5);
    chk8(ptr, 8'h22, "frozen pointer");
  endtask

  task automatic results();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    results();
  end
  initial begin
    #1 reset_n = 1'b0;
    cyc(6);
    reset_n = 1'b1;
    cyc(25);
    t_write();
    t_send_recv(1'b0);
    t_send_recv(1'b1);
    t_miss();
    t_freeze();
    t_alert();
    t_timeout();
    t_strap();
    results();
  end
endmodule
